// file: spw_top.sv
// Purpose: six-channel pwm generator with AXI4-Lite register access
// Assumes: host keeps duty strictly inside 0..100 percent
// Notes: buffer writes are converted to cycle counts by a shared divider
//
// Overview of operation
// - status bits 0-5 show running channels
// - start delay in 20 ns ticks before pulses
// - per-channel start level begins each period
// - mode bit 0 takes new values immediately
// - mode bit 1 limits output to count periods
// - mode bit 2 stops disabled channel immediately
// - period count 1 to 32768 per channel
// - configuration acts only once channel is enabled
// - latch pattern activates buffered values per channel
// - buffer writes alone never change running output
// - reset pattern stops selected channels at once
// - standby level bit per output
// - disabled or stopped output shows standby level
// - all outputs low after power-up
// - duty resolved in one percent steps
// - enable pattern enables ones, disables zeros
`timescale 1ns/1ps
`include "spw_defs.svh"
module spw_top
	import spw_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [5:0] pwm_out
);
	logic acc_r, bvalid_r, ar_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r, rd_nxt;
	logic rerr_nxt, wmap, wr_go;
	logic [5:0] en_r, sby_r, start_r, stop_r, kill_r, latch_r, run_w;
	logic [2:0] sel_r, cch_r;
	logic [6:0] duty_r;
	logic [31:0] freq_r;
	logic [31:0] dly_r [8];
	logic [3:0] mode_r [8];
	logic [15:0] cnt_r [8];
	logic [31:0] bper_r [8];
	logic [31:0] bhi_r [8];
	spw_cst_t cs_r;
	logic [31:0] cper_r, qper, qhi;
	logic div_start_r, div_done;
	logic [39:0] div_num_r, div_q;
	logic [31:0] div_den_r;

	assign s_axi_awready = acc_r;
	assign s_axi_wready = acc_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = ar_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign wr_go = acc_r && s_axi_wstrb == `SPW_STRB_ALL && wmap;

	// ----------------------------------------------------------------
	// write channel
	// ----------------------------------------------------------------
	always_comb
	begin
		case (s_axi_awaddr)
			`SPW_A_ENABLE, `SPW_A_LATCH, `SPW_A_RESET, `SPW_A_STANDBY,
			`SPW_A_SEL, `SPW_A_DELAY, `SPW_A_MODE, `SPW_A_COUNT,
			`SPW_A_DUTY, `SPW_A_FREQ: wmap = 1'b1;
			default: wmap = 1'b0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			acc_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `SPW_RESP_OK;
		end
		else
		begin
			acc_r <= !acc_r && s_axi_awvalid && s_axi_wvalid && !bvalid_r
				&& cs_r == CS_IDLE;
			if (acc_r)
			begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_go ? `SPW_RESP_OK : `SPW_RESP_ERR;
			end
			else if (s_axi_bready)
			begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// command pulses and global registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			en_r <= 6'h00;
			sby_r <= 6'h00;
			start_r <= 6'h00;
			stop_r <= 6'h00;
			kill_r <= 6'h00;
			latch_r <= 6'h00;
			sel_r <= 3'h0;
			duty_r <= 7'h00;
			freq_r <= 32'h0;
		end
		else
		begin
			start_r <= 6'h00;
			stop_r <= 6'h00;
			kill_r <= 6'h00;
			latch_r <= 6'h00;
			if (wr_go)
			begin
				case (s_axi_awaddr)
					`SPW_A_ENABLE:
					begin
						en_r <= s_axi_wdata[5:0];
						start_r <= s_axi_wdata[5:0] & ~run_w;
						stop_r <= ~s_axi_wdata[5:0] & run_w;
					end
					`SPW_A_LATCH: latch_r <= s_axi_wdata[5:0];
					`SPW_A_RESET: kill_r <= s_axi_wdata[5:0];
					`SPW_A_STANDBY: sby_r <= s_axi_wdata[5:0];
					`SPW_A_SEL: sel_r <= s_axi_wdata[2:0];
					`SPW_A_DUTY: duty_r <= s_axi_wdata[6:0];
					`SPW_A_FREQ: freq_r <= s_axi_wdata;
					default: sel_r <= sel_r;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// per-channel configuration, selected by sel
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < 8; i++)
			begin
				dly_r[i] <= 32'h0;
				mode_r[i] <= 4'h0;
				cnt_r[i] <= 16'h1;
			end
		end
		else if (wr_go)
		begin
			case (s_axi_awaddr)
				`SPW_A_DELAY: dly_r[sel_r] <= s_axi_wdata;
				`SPW_A_MODE: mode_r[sel_r] <= s_axi_wdata[3:0];
				`SPW_A_COUNT: cnt_r[sel_r] <= s_axi_wdata[15:0];
				default: cnt_r[sel_r] <= cnt_r[sel_r];
			endcase
		end
	end

	// ----------------------------------------------------------------
	// frequency and duty to cycle counts
	// ----------------------------------------------------------------
	assign qper = (div_q[39:32] != 8'h00) ? 32'hffff_ffff
		: (div_q[31:0] < `SPW_MIN_PER) ? `SPW_MIN_PER : div_q[31:0];
	assign qhi = (div_q[31:0] == 32'h0) ? 32'h1
		: (div_q[31:0] >= cper_r) ? cper_r - 32'h1 : div_q[31:0];

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cs_r <= CS_IDLE;
			cch_r <= 3'h0;
			cper_r <= `SPW_MIN_PER;
			div_start_r <= 1'b0;
			div_num_r <= 40'h0;
			div_den_r <= 32'h1;
			for (int i = 0; i < 8; i++)
			begin
				bper_r[i] <= `SPW_MIN_PER;
				bhi_r[i] <= 32'h1;
			end
		end
		else
		begin
			div_start_r <= 1'b0;
			case (cs_r)
				CS_IDLE:
				begin
					if (wr_go && s_axi_awaddr == `SPW_A_FREQ)
					begin
						cch_r <= sel_r;
						div_num_r <= `SPW_PER_NUM;
						div_den_r <= s_axi_wdata;
						div_start_r <= 1'b1;
						cs_r <= CS_PER;
					end
				end
				CS_PER:
				begin
					if (div_done)
					begin
						cper_r <= qper;
						div_num_r <= {8'h00, qper} * {33'h0, duty_r};
						div_den_r <= `SPW_PCT;
						div_start_r <= 1'b1;
						cs_r <= CS_HIGH;
					end
				end
				CS_HIGH:
				begin
					if (div_done)
					begin
						bper_r[cch_r] <= cper_r;
						bhi_r[cch_r] <= qhi;
						cs_r <= CS_IDLE;
					end
				end
				default: cs_r <= CS_IDLE;
			endcase
		end
	end

	spw_div i_spw_div (
		.clk(clk),
		.rst(rst),
		.start(div_start_r),
		.num(div_num_r),
		.den(div_den_r),
		.quo(div_q),
		.done(div_done)
	);

	// ----------------------------------------------------------------
	// channels
	// ----------------------------------------------------------------
	for (genvar g = 0; g < `SPW_NCH; g++)
	begin : g_ch
		spw_chan i_spw_chan (
			.clk(clk),
			.rst(rst),
			.start(start_r[g]),
			.stop(stop_r[g]),
			.kill(kill_r[g]),
			.latch(latch_r[g]),
			.buf_per(bper_r[g]),
			.buf_high(bhi_r[g]),
			.delay(dly_r[g]),
			.mode(mode_r[g]),
			.count(cnt_r[g]),
			.standby(sby_r[g]),
			.pwm_out(pwm_out[g]),
			.running(run_w[g])
		);
	end

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	always_comb
	begin
		rd_nxt = 32'h0;
		rerr_nxt = 1'b0;
		case (s_axi_araddr)
			`SPW_A_ENABLE: rd_nxt = {26'h0, en_r};
			`SPW_A_LATCH, `SPW_A_RESET: rd_nxt = 32'h0;
			`SPW_A_STANDBY: rd_nxt = {26'h0, sby_r};
			`SPW_A_STATUS: rd_nxt = {26'h0, run_w};
			`SPW_A_SEL: rd_nxt = {29'h0, sel_r};
			`SPW_A_DELAY: rd_nxt = dly_r[sel_r];
			`SPW_A_MODE: rd_nxt = {28'h0, mode_r[sel_r]};
			`SPW_A_COUNT: rd_nxt = {16'h0, cnt_r[sel_r]};
			`SPW_A_DUTY: rd_nxt = {25'h0, duty_r};
			`SPW_A_FREQ: rd_nxt = freq_r;
			`SPW_A_BUSY: rd_nxt = {31'h0, cs_r != CS_IDLE};
			default: rerr_nxt = 1'b1;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ar_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= `SPW_RESP_OK;
		end
		else
		begin
			ar_r <= !ar_r && s_axi_arvalid && !rvalid_r;
			if (ar_r)
			begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_nxt;
				rresp_r <= rerr_nxt ? `SPW_RESP_ERR : `SPW_RESP_OK;
			end
			else if (s_axi_rready)
			begin
				rvalid_r <= 1'b0;
			end
		end
	end

	rst_low_a: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> pwm_out == 6'h00)
		else $error("outputs not low after reset");
	status_read_a: assert property (@(posedge clk) disable iff (rst)
		ar_r && s_axi_araddr == `SPW_A_STATUS |=> s_axi_rdata == {26'h0, $past(run_w)})
		else $error("status word mismatch");
endmodule

// file: spw_defs.svh
// Purpose: shared constants of the six-channel pwm block
// Assumes: 40 MHz system clock, 32-bit AXI4-Lite register bus
// Notes: offsets are byte addresses of aligned words
`ifndef SPW_DEFS_SVH
`define SPW_DEFS_SVH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SPW_A_ENABLE 8'h00
`define SPW_A_LATCH 8'h04
`define SPW_A_RESET 8'h08
`define SPW_A_STANDBY 8'h0c
`define SPW_A_STATUS 8'h10
`define SPW_A_SEL 8'h14
`define SPW_A_DELAY 8'h18
`define SPW_A_MODE 8'h1c
`define SPW_A_COUNT 8'h20
`define SPW_A_DUTY 8'h24
`define SPW_A_FREQ 8'h28
`define SPW_A_BUSY 8'h2c
// ----------------------------------------------------------------
// fields and codes
// ----------------------------------------------------------------
`define SPW_NCH 6
`define SPW_M_TAKE 0
`define SPW_M_BURST 1
`define SPW_M_STOP 2
`define SPW_M_LVL 3
`define SPW_STRB_ALL 4'hf
`define SPW_RESP_OK 2'h0
`define SPW_RESP_ERR 2'h2
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SPW_TICK_NS 37'h14
`define SPW_CLK_NS 37'h19
// ns of one period at one frequency unit (0.05 Hz), as clock cycles
`define SPW_FREQ_NS 40'h4_a817_c800
`define SPW_PER_NUM (`SPW_FREQ_NS / 40'h19)
`define SPW_MIN_PER 32'h2
`define SPW_PCT 32'h64
`define SPW_DIV_STEPS 6'h28
`endif

// file: spw_pkg.sv
// Purpose: types of the six-channel pwm block
// Assumes: nothing
// Notes: one-hot state codes
package spw_pkg;
	typedef enum logic [2:0] {CH_IDLE = 3'h1, CH_DELAY = 3'h2, CH_RUN = 3'h4} spw_chst_t;
	typedef enum logic [2:0] {CS_IDLE = 3'h1, CS_PER = 3'h2, CS_HIGH = 3'h4} spw_cst_t;
endpackage

// file: spw_div.sv
// Purpose: serial restoring divider, one quotient bit per clock
// Assumes: start is a one-cycle pulse, operands held by the caller
// Notes: done pulses once, quo valid from then until next start
`timescale 1ns/1ps
`include "spw_defs.svh"
module spw_div
	import spw_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [39:0] num,
	input wire logic [31:0] den,
	output logic [39:0] quo,
	output logic done
);
	logic [40:0] rem_r;
	logic [39:0] q_r;
	logic [5:0] cnt_r;
	logic [40:0] sh;
	logic ge;

	assign sh = {rem_r[39:0], q_r[39]};
	assign ge = sh >= {9'h000, den};
	assign quo = q_r;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rem_r <= 41'h0;
			q_r <= 40'h0;
			cnt_r <= 6'h0;
			done <= 1'b0;
		end
		else if (start)
		begin
			rem_r <= 41'h0;
			q_r <= num;
			cnt_r <= `SPW_DIV_STEPS;
			done <= 1'b0;
		end
		else if (cnt_r != 6'h0)
		begin
			rem_r <= ge ? sh - {9'h000, den} : sh;
			q_r <= {q_r[38:0], ge};
			cnt_r <= cnt_r - 6'h1;
			done <= cnt_r == 6'h1;
		end
		else
		begin
			done <= 1'b0;
		end
	end
endmodule

// file: spw_chan.sv
// Purpose: one pwm channel: delay, periods, bursts, stop and standby
// Assumes: start, stop, kill and latch are one-cycle pulses
// Notes: period and high time are counts of 25 ns clock cycles
`timescale 1ns/1ps
`include "spw_defs.svh"
module spw_chan
	import spw_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic stop,
	input wire logic kill,
	input wire logic latch,
	input wire logic [31:0] buf_per,
	input wire logic [31:0] buf_high,
	input wire logic [31:0] delay,
	input wire logic [3:0] mode,
	input wire logic [15:0] count,
	input wire logic standby,
	output logic pwm_out,
	output logic running
);
	spw_chst_t st_r;
	logic [31:0] per_r, high_r, npe_r, nhi_r, cnt_r, cnt_nxt;
	logic [15:0] num_r, pcnt_r;
	logic [36:0] ns_r, tgt_r;
	logic [3:0] mode_r;
	logic pend_r, stopq_r, end_p, take;

	assign cnt_nxt = cnt_r + 32'h1;
	assign end_p = cnt_nxt >= per_r;
	assign take = pend_r && (st_r != CH_RUN || mode_r[`SPW_M_TAKE] || end_p);

	// ----------------------------------------------------------------
	// double-buffered frequency and duty
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			npe_r <= 32'h0;
			nhi_r <= 32'h0;
			pend_r <= 1'b0;
		end
		else if (latch)
		begin
			npe_r <= buf_per;
			nhi_r <= buf_high;
			pend_r <= 1'b1;
		end
		else if (take)
		begin
			pend_r <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			per_r <= `SPW_MIN_PER;
			high_r <= 32'h1;
		end
		else if (take)
		begin
			per_r <= npe_r;
			high_r <= nhi_r;
		end
	end

	// ----------------------------------------------------------------
	// channel sequence
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_r <= CH_IDLE;
			pwm_out <= 1'b0;
			running <= 1'b0;
			cnt_r <= 32'h0;
			pcnt_r <= 16'h0;
			num_r <= 16'h0;
			ns_r <= 37'h0;
			tgt_r <= 37'h0;
			mode_r <= 4'h0;
			stopq_r <= 1'b0;
		end
		else if (st_r != CH_IDLE && (kill || (stop && mode_r[`SPW_M_STOP])))
		begin
			st_r <= CH_IDLE;
			pwm_out <= standby;
			running <= 1'b0;
		end
		else
		begin
			case (st_r)
				CH_IDLE:
				begin
					pwm_out <= standby;
					if (start)
					begin
						mode_r <= mode;
						num_r <= count;
						tgt_r <= {5'h00, delay} * `SPW_TICK_NS;
						ns_r <= 37'h0;
						stopq_r <= 1'b0;
						running <= 1'b1;
						st_r <= CH_DELAY;
					end
				end
				CH_DELAY:
				begin
					if (stop)
					begin
						st_r <= CH_IDLE;
						pwm_out <= standby;
						running <= 1'b0;
					end
					else if (ns_r >= tgt_r)
					begin
						st_r <= CH_RUN;
						cnt_r <= 32'h0;
						pcnt_r <= 16'h0;
						pwm_out <= mode_r[`SPW_M_LVL];
					end
					else
					begin
						ns_r <= ns_r + `SPW_CLK_NS;
					end
				end
				CH_RUN:
				begin
					if (stop)
					begin
						stopq_r <= 1'b1;
					end
					if (end_p)
					begin
						if (stop || stopq_r
							|| (mode_r[`SPW_M_BURST] && pcnt_r == num_r - 16'h1))
						begin
							st_r <= CH_IDLE;
							pwm_out <= standby;
							running <= 1'b0;
						end
						else
						begin
							cnt_r <= 32'h0;
							pcnt_r <= pcnt_r + 16'h1;
							pwm_out <= mode_r[`SPW_M_LVL];
						end
					end
					else
					begin
						cnt_r <= cnt_nxt;
						pwm_out <= (cnt_nxt < high_r) ? mode_r[`SPW_M_LVL]
							: ~mode_r[`SPW_M_LVL];
					end
				end
				default:
				begin
					st_r <= CH_IDLE;
					running <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	idle_standby_a: assert property (@(posedge clk) disable iff (rst)
		!running && $past(!running) |-> pwm_out == $past(standby))
		else $error("idle output differs from standby level");
	kill_stops_a: assert property (@(posedge clk) disable iff (rst)
		kill && running |=> !running)
		else $error("reset command did not stop channel");
	imm_stop_a: assert property (@(posedge clk) disable iff (rst)
		stop && running && mode_r[`SPW_M_STOP] |=> !running && pwm_out == $past(standby))
		else $error("immediate stop missed");
	burst_end_a: assert property (@(posedge clk) disable iff (rst)
		$fell(running) |-> pwm_out == $past(standby))
		else $error("status and standby not in same cycle");
	start_runs_a: assert property (@(posedge clk) disable iff (rst)
		start && !running |=> running ##1 (running || $past(stop || kill)))
		else $error("enable did not start channel");
	first_level_a: assert property (@(posedge clk) disable iff (rst)
		st_r == CH_RUN && $past(st_r) == CH_DELAY |-> pwm_out == mode_r[`SPW_M_LVL])
		else $error("period did not begin at start level");
	delay_done_a: assert property (@(posedge clk) disable iff (rst)
		st_r == CH_RUN && $past(st_r) == CH_DELAY |-> $past(ns_r) >= $past(tgt_r))
		else $error("start delay cut short");
	burst_count_a: assert property (@(posedge clk) disable iff (rst)
		st_r == CH_RUN && end_p && mode_r[`SPW_M_BURST] && pcnt_r == num_r - 16'h1
		|=> !running)
		else $error("burst did not finish after count periods");
	imm_take_a: assert property (@(posedge clk) disable iff (rst)
		latch && mode_r[`SPW_M_TAKE] && !start |-> ##2 per_r == $past(buf_per, 2))
		else $error("immediate take-over missed");
endmodule

// file: test_spw_top.sv
// Purpose: self-checking bench of the six-channel pwm block
// Assumes: 40 MHz clock; bus tasks act as an AXI4-Lite master
// Notes: channel timing is judged by counting high cycles of an output
`timescale 1ns/1ps
`include "spw_defs.svh"
module test_spw_top;
	// ----------------------------------------------------------------
	// signals and design
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = `SPW_STRB_ALL;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic [5:0] pwm_out;
	int failures = 0;
	int checks_done = 0;
	localparam logic [31:0] FREQ_10 = 32'h04c4_b400;
	always #12.5 clk = ~clk;
	spw_top i_spw_top (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .pwm_out(pwm_out));
	// ----------------------------------------------------------------
	// checking and closing
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_p;
		logic w_p;
		aw_p = 1'b1;
		w_p = 1'b1;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (aw_p && s_axi_awready === 1'b1)
			begin
				aw_p = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w_p && s_axi_wready === 1'b1)
			begin
				w_p = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (aw_p || w_p);
		while (s_axi_bvalid !== 1'b1)
			@(posedge clk);
		chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
			@(posedge clk);
		while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1)
			@(posedge clk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(nm, d, exp);
	endtask
	// ----------------------------------------------------------------
	// channel helpers
	// ----------------------------------------------------------------
	task automatic bufw(input logic [31:0] duty, input logic [31:0] freq);
		logic [31:0] d;
		logic [1:0] r;
		wr(`SPW_A_DUTY, duty, `SPW_RESP_OK);
		wr(`SPW_A_FREQ, freq, `SPW_RESP_OK);
		do
			rd(`SPW_A_BUSY, d, r);
		while (d[0] !== 1'b0);
	endtask
	task automatic cfg(input logic [31:0] ch, input logic [31:0] dly, input logic [31:0] md,
		input logic [31:0] cnt, input logic [31:0] duty);
		wr(`SPW_A_SEL, ch, `SPW_RESP_OK);
		wr(`SPW_A_DELAY, dly, `SPW_RESP_OK);
		wr(`SPW_A_MODE, md, `SPW_RESP_OK);
		wr(`SPW_A_COUNT, cnt, `SPW_RESP_OK);
		bufw(duty, FREQ_10);
		wr(`SPW_A_LATCH, 32'h1 << ch, `SPW_RESP_OK);
	endtask
	task automatic hi(input int ch, input int n, input logic [31:0] exp);
		logic [31:0] c;
		c = 32'h0;
		repeat (n)
		begin
			@(posedge clk);
			if (pwm_out[ch] === 1'b1)
				c = c + 32'h1;
			else if (pwm_out[ch] !== 1'b0)
				c = c + 32'h100;
		end
		chk("high cycles", c, exp);
	endtask
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		chk("pwm after reset", {26'h0, pwm_out}, 32'h0);
		rchk("status", `SPW_A_STATUS, 32'h0);
		rchk("count reset", `SPW_A_COUNT, 32'h1);
		wr(`SPW_A_COUNT, 32'h8000, `SPW_RESP_OK);
		rchk("count max", `SPW_A_COUNT, 32'h8000);
		rd(8'h30, d, r);
		chk("unmapped rresp", {30'h0, r}, {30'h0, `SPW_RESP_ERR});
		wr(`SPW_A_STATUS, 32'h3f, `SPW_RESP_ERR);
		s_axi_wstrb <= 4'h3;
		wr(`SPW_A_SEL, 32'h5, `SPW_RESP_ERR);
		s_axi_wstrb <= `SPW_STRB_ALL;
		rchk("sel kept", `SPW_A_SEL, 32'h0);
		wr(`SPW_A_STANDBY, 32'h2a, `SPW_RESP_OK);
		repeat (2) @(posedge clk);
		chk("standby", {26'h0, pwm_out}, 32'h2a);
		$display("test registers done");
		// burst of two 10-cycle periods at 30 percent, high start level
		cfg(0, 0, 32'ha, 2, 30);
		hi(0, 20, 0);
		wr(`SPW_A_ENABLE, 32'h1, `SPW_RESP_OK);
		hi(0, 60, 6);
		rchk("status after burst", `SPW_A_STATUS, 32'h0);
		cfg(0, 0, 32'h2, 2, 30);
		wr(`SPW_A_ENABLE, 32'h1, `SPW_RESP_OK);
		hi(0, 60, 14);
		$display("test burst done");
		// continuous channel 1 with a start delay of 80 cycles
		cfg(1, 100, 32'h8, 1, 50);
		wr(`SPW_A_ENABLE, 32'h2, `SPW_RESP_OK);
		hi(1, 70, 70);
		repeat (20) @(posedge clk);
		hi(1, 100, 50);
		rchk("status running", `SPW_A_STATUS, 32'h2);
		bufw(20, FREQ_10);
		hi(1, 100, 50);
		wr(`SPW_A_LATCH, 32'h1, `SPW_RESP_OK);
		hi(1, 100, 50);
		wr(`SPW_A_LATCH, 32'h2, `SPW_RESP_OK);
		repeat (15) @(posedge clk);
		hi(1, 100, 20);
		$display("test latch done");
		wr(`SPW_A_RESET, 32'h2, `SPW_RESP_OK);
		repeat (2) @(posedge clk);
		hi(1, 20, 20);
		rchk("status after kill", `SPW_A_STATUS, 32'h0);
		cfg(1, 0, 32'hd, 1, 50);
		wr(`SPW_A_ENABLE, 32'h2, `SPW_RESP_OK);
		repeat (30) @(posedge clk);
		// immediate take-over: new high time counts right after the latch
		bufw(20, FREQ_10);
		wr(`SPW_A_LATCH, 32'h2, `SPW_RESP_OK);
		repeat (2) @(posedge clk);
		hi(1, 100, 20);
		wr(`SPW_A_ENABLE, 32'h0, `SPW_RESP_OK);
		repeat (2) @(posedge clk);
		hi(1, 20, 20);
		rchk("status after stop", `SPW_A_STATUS, 32'h0);
		$display("test stop done");
		results();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("watchdog expired");
		results();
	end
endmodule
